// ### src/ebc_core.sv
// control core of an external parallel bus interface
// assumes a same-clock register port and same-clock fifo datapath beside it;
// the hold-off pin comes from outside and is synchronised here
`timescale 1ns/1ps

module ebc_core #(
	parameter int WR_DEPTH = 16,
	parameter int RD_DEPTH = 8,
	parameter int WR_W     = $clog2(WR_DEPTH + 1),
	parameter int RD_W     = $clog2(RD_DEPTH + 1)
) (
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	input  wire logic              clk_en,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	input  wire logic [WR_W-1:0]   wr_fill,
	input  wire logic [RD_W-1:0]   rd_fill,
	input  wire logic              wr_attempt,
	input  wire logic              rd_stall,
	input  wire logic              xact_busy,
	input  wire logic              dual_rate,
	input  wire logic              cs_second_sel,
	input  wire logic              ext_clk_ena_pin,
	output logic                   if_enable,
	output logic                   ext_clk,
	output logic                   ext_clk_tick,
	output logic                   mem_self_refresh,
	output logic                   refresh_req,
	output logic                   xact_abort,
	output logic                   irq
);
	// ==================================================
	// registers
	ebc_pkg::ebc_op_sel_type   mode_reg;
	logic [31:0]               div_reg;
	ebc_pkg::ebc_mem_cfg_type  mem_reg;
	ebc_pkg::ebc_fifo_cfg_type fifo_reg;
	logic [15:0]               max_wait_reg;
	logic [2:0]                int_en_reg;
	logic [2:0]                cause_reg;
	logic [2:0]                cause_next;
	logic [2:0]                raw_sts;
	logic                      tx_req;
	logic                      rx_req;
	logic                      ena_meta_reg;
	logic                      ena_sync_reg;
	logic [15:0]               wait_cnt_reg;
	logic [15:0]               half_cnt_reg;
	logic [15:0]               div_sel;
	logic [15:0]               half_sel;
	logic [10:0]               ref_cnt_reg;
	logic [WR_W-1:0]           tx_thr;
	logic [RD_W-1:0]           rx_thr;
	logic [WR_W-1:0]           wr_free;
	logic                      wfull_evt;
	logic                      rstall_evt;
	logic                      tout_evt;
	logic                      wr_hit;

	assign wr_hit = clk_en && reg_wr;

	// ==================================================
	// configuration writes
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			mode_reg     <= ebc_pkg::op_sel_off;
			div_reg      <= ebc_pkg::RST_DIVIDER;
			mem_reg      <= ebc_pkg::RST_MEMCFG;
			fifo_reg     <= ebc_pkg::RST_FIFOCFG;
			max_wait_reg <= ebc_pkg::RST_MAXWAIT;
			int_en_reg   <= ebc_pkg::RST_INTEN;
		end else if (wr_hit) begin
			unique case (reg_addr)
				ebc_pkg::OFF_MODE: begin
					// unknown codes fall back to off so if_enable and the clock tick stay low
					if (reg_wdata[2:0] <= 3'h4) begin
						mode_reg <= ebc_pkg::ebc_op_sel_type'(reg_wdata[2:0]);
					end else begin
						mode_reg <= ebc_pkg::op_sel_off;
					end
				end
				ebc_pkg::OFF_DIVIDER: div_reg <= reg_wdata;
				ebc_pkg::OFF_MEMCFG:  mem_reg <= reg_wdata;
				ebc_pkg::OFF_FIFOCFG: fifo_reg <= reg_wdata;
				ebc_pkg::OFF_MAXWAIT: max_wait_reg <= reg_wdata[15:0];
				ebc_pkg::OFF_INTEN:   int_en_reg <= reg_wdata[2:0];
				default: ;
			endcase
		end
	end

	// ==================================================
	// fifo trigger thresholds
	always_comb begin
		unique case (fifo_reg.tx_level)
			2'h0:    tx_thr = '0;
			2'h1:    tx_thr = WR_W'(WR_DEPTH / 4);
			2'h2:    tx_thr = WR_W'(WR_DEPTH / 2);
			default: tx_thr = WR_W'(WR_DEPTH * 3 / 4);
		endcase
	end

	always_comb begin
		unique case (fifo_reg.rx_level)
			3'h0:    rx_thr = RD_W'(RD_DEPTH / 8);
			3'h1:    rx_thr = RD_W'(RD_DEPTH / 4);
			3'h2:    rx_thr = RD_W'(RD_DEPTH / 2);
			3'h3:    rx_thr = RD_W'(RD_DEPTH * 3 / 4);
			3'h4:    rx_thr = RD_W'(RD_DEPTH * 7 / 8);
			default: rx_thr = RD_W'(RD_DEPTH);
		endcase
	end

	// empty level can't be undershot, so it asks while the fifo is empty
	assign tx_req = (fifo_reg.tx_level == ebc_pkg::TX_EMPTY) ?
		(wr_fill == '0) : (wr_fill < tx_thr);
	// full level can't be exceeded, so it asks while the fifo is full
	assign rx_req = (fifo_reg.rx_level >= ebc_pkg::RX_FULL) ?
		(rd_fill >= rx_thr) : (rd_fill > rx_thr);

	assign wr_free = WR_W'(WR_DEPTH) - wr_fill;

	// ==================================================
	// hold-off pin synchroniser
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			// reset to the idle (ready) level so no false hold-off follows reset
			ena_meta_reg <= 1'b1;
			ena_sync_reg <= 1'b1;
		end else if (clk_en) begin
			ena_meta_reg <= ext_clk_ena_pin;
			ena_sync_reg <= ena_meta_reg;
		end
	end

	// ==================================================
	// hold-off wait counter and abort
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wait_cnt_reg <= '0;
			xact_abort   <= 1'b0;
		end else if (clk_en) begin
			xact_abort <= tout_evt;
			if (!xact_busy || ena_sync_reg || tout_evt) begin
				wait_cnt_reg <= '0;
			end else if (wait_cnt_reg != 16'hffff) begin
				wait_cnt_reg <= wait_cnt_reg + 16'h0001;
			end
		end
	end

	// zero wait count never times out
	assign tout_evt = xact_busy && !ena_sync_reg && (max_wait_reg != '0) &&
		(wait_cnt_reg >= max_wait_reg);

	// ==================================================
	// error causes
	assign wfull_evt  = fifo_reg.write_full_err_enable && wr_attempt &&
		(wr_fill >= WR_W'(WR_DEPTH));
	assign rstall_evt = fifo_reg.read_stall_err_enable && rd_stall;

	always_comb begin
		cause_next = cause_reg;
		if (wr_hit && reg_addr == ebc_pkg::OFF_ERRCLR) begin
			cause_next = cause_reg & ~reg_wdata[2:0];
		end
		// a new event beats a clear in the same cycle
		cause_next[ebc_pkg::IDX_WFULL]   = cause_next[ebc_pkg::IDX_WFULL] | wfull_evt;
		cause_next[ebc_pkg::IDX_RSTALL]  = cause_next[ebc_pkg::IDX_RSTALL] | rstall_evt;
		cause_next[ebc_pkg::IDX_TIMEOUT] = cause_next[ebc_pkg::IDX_TIMEOUT] | tout_evt;
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cause_reg <= '0;
		end else if (clk_en) begin
			cause_reg <= cause_next;
		end
	end

	always_comb begin
		raw_sts = '0;
		raw_sts[ebc_pkg::IDX_TXREQ] = tx_req;
		raw_sts[ebc_pkg::IDX_RXREQ] = rx_req;
		raw_sts[ebc_pkg::IDX_ERR]   = |cause_reg;
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(raw_sts & int_en_reg);
		end
	end

	// ==================================================
	// register reads, data valid the cycle after the strobe only
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			reg_rdata <= '0;
		end else if (clk_en) begin
			reg_rdata <= '0;
			if (reg_rd) begin
				unique case (reg_addr)
					ebc_pkg::OFF_MODE:    reg_rdata <= {29'h0, mode_reg};
					ebc_pkg::OFF_DIVIDER: reg_rdata <= div_reg;
					ebc_pkg::OFF_MEMCFG:  reg_rdata <= mem_reg;
					ebc_pkg::OFF_FIFOCFG: reg_rdata <= fifo_reg;
					ebc_pkg::OFF_MAXWAIT: reg_rdata <= {16'h0, max_wait_reg};
					ebc_pkg::OFF_INTEN:   reg_rdata <= {29'h0, int_en_reg};
					ebc_pkg::OFF_RAWSTS:  reg_rdata <= {29'h0, raw_sts};
					ebc_pkg::OFF_MSKSTS:  reg_rdata <= {29'h0, raw_sts & int_en_reg};
					ebc_pkg::OFF_ERRSTS:  reg_rdata <= {29'h0, cause_reg};
					ebc_pkg::OFF_RDCOUNT: reg_rdata <= 32'(rd_fill);
					ebc_pkg::OFF_WRFREE:  reg_rdata <= 32'(wr_free);
					default:              reg_rdata <= '0;
				endcase
			end
		end
	end

	// ==================================================
	// external clock divider
	assign div_sel  = (dual_rate && cs_second_sel) ? div_reg[31:16] : div_reg[15:0];
	assign half_sel = {1'b0, div_sel[15:1]};

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			half_cnt_reg <= '0;
			ext_clk      <= 1'b0;
			ext_clk_tick <= 1'b0;
		end else if (clk_en) begin
			if (div_sel == '0) begin
				// undivided: the tick runs every cycle as the clock enable
				half_cnt_reg <= '0;
				ext_clk      <= ~ext_clk;
				ext_clk_tick <= if_enable;
			end else if (half_cnt_reg >= half_sel) begin
				// each half period lasts div/2+1 system clocks
				half_cnt_reg <= '0;
				ext_clk      <= ~ext_clk;
				ext_clk_tick <= if_enable && !ext_clk;
			end else begin
				half_cnt_reg <= half_cnt_reg + 16'h0001;
				ext_clk_tick <= 1'b0;
			end
		end
	end

	// ==================================================
	// mode outputs and refresh scheduler
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			if_enable        <= 1'b0;
			mem_self_refresh <= 1'b0;
		end else if (clk_en) begin
			if_enable        <= (mode_reg != ebc_pkg::op_sel_off);
			mem_self_refresh <= (mode_reg == ebc_pkg::op_sel_dynamic_memory) &&
				(mem_reg.power == ebc_pkg::mem_self_refresh_sel);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ref_cnt_reg <= '0;
			refresh_req <= 1'b0;
		end else if (clk_en) begin
			refresh_req <= 1'b0;
			// in self-refresh the memory keeps itself, so no pulses go out
			if (mode_reg != ebc_pkg::op_sel_dynamic_memory ||
				mem_reg.power == ebc_pkg::mem_self_refresh_sel ||
				mem_reg.refresh_interval == '0) begin
				ref_cnt_reg <= '0;
			end else if (ref_cnt_reg >= mem_reg.refresh_interval - 11'h001) begin
				ref_cnt_reg <= '0;
				refresh_req <= 1'b1;
			end else begin
				ref_cnt_reg <= ref_cnt_reg + 11'h001;
			end
		end
	end
endmodule : ebc_core

// ### src/ebc_pkg.sv
// constants, field layouts and carriers for the external bus control core
// assumes a 32-bit register port with one word per register
package ebc_pkg;
	// ==================================================
	// register byte offsets
	localparam logic [7:0] OFF_MODE    = 8'h00;
	localparam logic [7:0] OFF_DIVIDER = 8'h04;
	localparam logic [7:0] OFF_MEMCFG  = 8'h08;
	localparam logic [7:0] OFF_FIFOCFG = 8'h0c;
	localparam logic [7:0] OFF_MAXWAIT = 8'h10;
	localparam logic [7:0] OFF_INTEN   = 8'h14;
	localparam logic [7:0] OFF_RAWSTS  = 8'h18;
	localparam logic [7:0] OFF_MSKSTS  = 8'h1c;
	localparam logic [7:0] OFF_ERRSTS  = 8'h20;
	localparam logic [7:0] OFF_ERRCLR  = 8'h24;
	localparam logic [7:0] OFF_RDCOUNT = 8'h28;
	localparam logic [7:0] OFF_WRFREE  = 8'h2c;

	// ==================================================
	// operating selections
	typedef enum logic [2:0] {
		op_sel_general_purpose = 3'h0,
		op_sel_dynamic_memory  = 3'h1,
		op_sel_host_bus_narrow = 3'h2,
		op_sel_host_bus_wide   = 3'h3,
		op_sel_off             = 3'h4
	} ebc_op_sel_type;

	// core clock bands: <=15, <=30, <=50, <=100 MHz
	localparam logic [1:0] BAND_0_15   = 2'h0;
	localparam logic [1:0] BAND_15_30  = 2'h1;
	localparam logic [1:0] BAND_30_50  = 2'h2;
	localparam logic [1:0] BAND_50_100 = 2'h3;

	localparam logic mem_normal_power_sel = 1'b0;
	localparam logic mem_self_refresh_sel = 1'b1;

	// device size: 64, 128, 256, 512 Mbit
	localparam logic [1:0] SIZE_64M  = 2'h0;
	localparam logic [1:0] SIZE_128M = 2'h1;
	localparam logic [1:0] SIZE_256M = 2'h2;
	localparam logic [1:0] SIZE_512M = 2'h3;

	// ==================================================
	// dynamic memory config word: band [1:0], power [4], size [7:6], refresh [26:16]
	typedef struct packed {
		logic [4:0]  pad_hi;
		logic [10:0] refresh_interval;
		logic [7:0]  pad_mid;
		logic [1:0]  size;
		logic        pad_b5;
		logic        power;
		logic [1:0]  pad_lo;
		logic [1:0]  band;
	} ebc_mem_cfg_type;

	// fifo config word: tx level [1:0], rx level [6:4], error enables [8], [9]
	typedef struct packed {
		logic [21:0] pad_hi;
		logic        read_stall_err_enable;
		logic        write_full_err_enable;
		logic        pad_b7;
		logic [2:0]  rx_level;
		logic [1:0]  pad_lo;
		logic [1:0]  tx_level;
	} ebc_fifo_cfg_type;

	localparam logic [1:0] TX_EMPTY = 2'h0;
	localparam logic [2:0] RX_FULL  = 3'h5;

	// status bit positions
	localparam int IDX_TXREQ = 0;
	localparam int IDX_RXREQ = 1;
	localparam int IDX_ERR   = 2;
	localparam int IDX_WFULL = 0;
	localparam int IDX_RSTALL = 1;
	localparam int IDX_TIMEOUT = 2;

	// reset values
	localparam logic [31:0] RST_DIVIDER = 32'h0000_0000;
	localparam logic [31:0] RST_MEMCFG  = 32'h0000_0000;
	localparam logic [31:0] RST_FIFOCFG = 32'h0000_0000;
	localparam logic [15:0] RST_MAXWAIT = 16'h0000;
	localparam logic [2:0]  RST_INTEN   = 3'h0;
endpackage : ebc_pkg

// ### testbench/ebc_monitor.sv
// port-level checker for the external bus control core
// assumes a bind onto ebc_core; one clock, synchronous active-low reset
`timescale 1ns/1ps
module ebc_monitor #(
	parameter int WR_DEPTH = 16,
	parameter int RD_DEPTH = 8,
	parameter int WR_W     = 5,
	parameter int RD_W     = 4
) (
	input wire logic            sys_clk,
	input wire logic            reset_n,
	input wire logic            clk_en,
	input wire logic [7:0]      reg_addr,
	input wire logic [31:0]     reg_wdata,
	input wire logic            reg_wr,
	input wire logic            reg_rd,
	input wire logic [31:0]     reg_rdata,
	input wire logic [WR_W-1:0] wr_fill,
	input wire logic [RD_W-1:0] rd_fill,
	input wire logic            if_enable,
	input wire logic            ext_clk_tick,
	input wire logic            refresh_req,
	input wire logic            xact_abort,
	input wire logic            irq
);
	// ==================================================
	// sequences and assertions
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence rd_at(logic [7:0] a);
		reg_rd && clk_en && reg_addr == a;
	endsequence
	sequence mode_wr;
		reg_wr && clk_en && reg_addr == ebc_pkg::OFF_MODE;
	endsequence
	rdata_idle_a: assert property (!(reg_rd && clk_en) |=> reg_rdata == 32'h0)
		else $error("read data not idle");
	mode_enable_a: assert property (mode_wr |=> ##1 if_enable == ($past(reg_wdata[2:0], 2) < 3'h4))
		else $error("enable does not follow mode");
	tick_gate_a: assert property (!if_enable && $past(!if_enable) |-> !ext_clk_tick)
		else $error("clock tick while disabled");
	abort_pulse_a: assert property (xact_abort |=> !xact_abort)
		else $error("abort longer than one cycle");
	refresh_pulse_a: assert property (refresh_req |=> !refresh_req)
		else $error("refresh request too long");
	unmapped_read_a: assert property (rd_at(8'h40) or rd_at(ebc_pkg::OFF_ERRCLR) |=> reg_rdata == 32'h0)
		else $error("unmapped or clear read not zero");
	masked_irq_a: assert property (rd_at(ebc_pkg::OFF_MSKSTS) |=> irq == (reg_rdata[2:0] != 3'h0))
		else $error("irq differs from masked status");
	rd_count_a: assert property (rd_at(ebc_pkg::OFF_RDCOUNT) |=> reg_rdata == 32'($past(rd_fill)))
		else $error("read fifo count wrong");
	wr_free_a: assert property (rd_at(ebc_pkg::OFF_WRFREE) |=> reg_rdata == 32'(WR_DEPTH) - 32'($past(wr_fill)))
		else $error("write free count wrong");
endmodule : ebc_monitor

bind ebc_core ebc_monitor #(.WR_DEPTH(WR_DEPTH), .RD_DEPTH(RD_DEPTH), .WR_W(WR_W), .RD_W(RD_W)) u_ebc_monitor (.*);

// ### testbench/ebc_hold_model.sv
// far-side peripheral: drives the hold-off ready pin
// assumes the bench sets hold_len before raising xact_busy
`timescale 1ns/1ps
module ebc_hold_model (
	input  wire logic       sys_clk,
	input  wire logic       xact_busy,
	input  wire logic [7:0] hold_len,
	output logic            ext_clk_ena_pin
);
	// ==================================================
	// hold-off counter
	logic [7:0] held_reg;
	always_ff @(posedge sys_clk) begin
		if (!xact_busy) held_reg <= 8'h0;
		else if (held_reg != 8'hff) held_reg <= held_reg + 8'h1;
	end
	// idles high (ready); low only while a transfer is held off
	assign ext_clk_ena_pin = !(xact_busy && held_reg < hold_len);
endmodule : ebc_hold_model

// ### testbench/test_external_bus_ctrl_core.sv
// self-checking bench for the external bus control core
// assumes default depths 16/8 and the hold-off partner model
`timescale 1ns/1ps
module test_external_bus_ctrl_core;
	// ==================================================
	// signals and instances
	logic        sys_clk, reset_n, reg_wr, reg_rd, wr_attempt, rd_stall, xact_busy, dual_rate, cs_second_sel;
	logic        clk_en, ext_clk_ena_pin, if_enable, ext_clk, ext_clk_tick, mem_self_refresh, refresh_req;
	logic        xact_abort, irq;
	logic [7:0]  reg_addr, hold_len;
	logic [31:0] reg_wdata, reg_rdata;
	logic [4:0]  wr_fill;
	logic [3:0]  rd_fill;
	int          error_cnt, total_checks, tk, rf, ab, hc, i, j, f, d;
	int          thr [6] = '{1, 2, 4, 6, 7, 8};
	int          mw [3] = '{0, 3, 20};
	int          hl [3] = '{40, 40, 5};
	logic [31:0] dv [5] = '{32'h0, 32'h1, 32'h1_0004, 32'h1_0004, 32'h4_0003};
	ebc_core u_ebc_core (.*);
	ebc_hold_model u_ebc_hold_model (.*);
	always #2 sys_clk = ~sys_clk;

	// ==================================================
	// tasks
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		// data launched at the previous edge still stands before this edge updates it
		@(posedge sys_clk);
		cmp(reg_rdata, e);
	endtask : rd
	task automatic pulse(input int k);
		@(posedge sys_clk);
		wr_attempt <= (k == 0);
		rd_stall <= (k == 1);
		@(posedge sys_clk);
		wr_attempt <= 1'b0;
		rd_stall <= 1'b0;
	endtask : pulse
	// counts events over n cycles; windows are whole periods so phase does not matter
	task automatic count(input int n);
		tk = 0;
		rf = 0;
		ab = 0;
		hc = 0;
		repeat (n) @(posedge sys_clk) begin
			tk += ext_clk_tick;
			hc += ext_clk;
			rf += refresh_req;
			ab += xact_abort;
		end
	endtask : count
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude

	// ==================================================
	// tests
	initial begin : main
		ebc_pkg::ebc_mem_cfg_type  mc;
		ebc_pkg::ebc_fifo_cfg_type fc;
		{sys_clk, reset_n, reg_wr, reg_rd, wr_attempt, rd_stall, xact_busy, dual_rate, cs_second_sel} = '0;
		clk_en = 1'b1;
		{reg_addr, hold_len, reg_wdata, wr_fill, rd_fill} = '0;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(ebc_pkg::OFF_MODE, 32'h4);
		rd(ebc_pkg::OFF_MEMCFG, ebc_pkg::RST_MEMCFG);
		rd(8'h40, 32'h0);
		clk_en <= 1'b0;
		wr(ebc_pkg::OFF_MAXWAIT, 32'h5);
		clk_en <= 1'b1;
		rd(ebc_pkg::OFF_MAXWAIT, 32'h0);
		for (i = 0; i < 8; i++) begin
			wr(ebc_pkg::OFF_MODE, 32'(i));
			rd(ebc_pkg::OFF_MODE, (i > 4) ? 32'h4 : 32'(i));
			cmp(if_enable, 32'(i < 4));
		end
		$display("test modes done");
		wr(ebc_pkg::OFF_MODE, 32'h0);
		for (i = 0; i < 5; i++) begin
			dual_rate <= (i == 2 || i == 3);
			cs_second_sel <= (i >= 3);
			wr(ebc_pkg::OFF_DIVIDER, dv[i]);
			rd(ebc_pkg::OFF_DIVIDER, dv[i]);
			d = (i == 3) ? int'(dv[i][31:16]) : int'(dv[i][15:0]);
			repeat (12) @(posedge sys_clk);
			count(60);
			cmp(32'(tk), (d == 0) ? 32'd60 : 32'(60 / (2 * (d / 2 + 1))));
			cmp(32'(hc), 32'd30);
		end
		$display("test divider done");
		wr(ebc_pkg::OFF_MODE, 32'h1);
		for (i = 0; i < 4; i++) begin
			mc = '0;
			mc.band = 2'(i);
			mc.size = 2'(3 - i);
			mc.power = i[0];
			mc.refresh_interval = (i == 3) ? 11'h7ff : 11'h005;
			wr(ebc_pkg::OFF_MEMCFG, mc);
			rd(ebc_pkg::OFF_MEMCFG, mc);
			repeat (4) @(posedge sys_clk);
			count(50);
			cmp(mem_self_refresh, 32'(i[0]));
			cmp(32'(rf), i[0] ? 32'h0 : 32'd10);
		end
		$display("test memory done");
		fc = '0;
		fc.rx_level = ebc_pkg::RX_FULL;
		for (i = 0; i < 4; i++) begin
			fc.tx_level = 2'(i);
			wr(ebc_pkg::OFF_FIFOCFG, fc);
			for (j = 0; j < 2; j++) begin
				f = (i == 0) ? j : 4 * i - 1 + j;
				wr_fill <= 5'(f);
				rd(ebc_pkg::OFF_RAWSTS, 32'((i == 0) ? f == 0 : f < 4 * i));
				rd(ebc_pkg::OFF_WRFREE, 32'(16 - f));
			end
		end
		wr_fill <= 5'h5;
		fc.tx_level = ebc_pkg::TX_EMPTY;
		for (i = 0; i < 6; i++) begin
			fc.rx_level = 3'(i);
			wr(ebc_pkg::OFF_FIFOCFG, fc);
			for (j = 0; j < 2; j++) begin
				f = thr[i] + j - 32'(i == 5);
				rd_fill <= 4'(f);
				rd(ebc_pkg::OFF_RAWSTS, 32'(2 * ((i == 5) ? f >= 8 : f > thr[i])));
				rd(ebc_pkg::OFF_RDCOUNT, 32'(f));
			end
		end
		$display("test levels done");
		fc = '0;
		fc.write_full_err_enable = 1'b1;
		fc.read_stall_err_enable = 1'b1;
		wr(ebc_pkg::OFF_FIFOCFG, fc);
		rd_fill <= 4'h0;
		wr_fill <= 5'd15;
		pulse(0);
		rd(ebc_pkg::OFF_ERRSTS, 32'h0);
		wr_fill <= 5'd16;
		pulse(0);
		rd(ebc_pkg::OFF_ERRSTS, 32'h1);
		pulse(1);
		rd(ebc_pkg::OFF_ERRSTS, 32'h3);
		rd(ebc_pkg::OFF_RAWSTS, 32'h4);
		wr(ebc_pkg::OFF_INTEN, 32'h4);
		rd(ebc_pkg::OFF_MSKSTS, 32'h4);
		cmp(irq, 32'h1);
		wr(ebc_pkg::OFF_INTEN, 32'h3);
		rd(ebc_pkg::OFF_MSKSTS, 32'h0);
		cmp(irq, 32'h0);
		wr(ebc_pkg::OFF_ERRCLR, 32'h1);
		rd(ebc_pkg::OFF_ERRSTS, 32'h2);
		rd(ebc_pkg::OFF_RAWSTS, 32'h4);
		wr(ebc_pkg::OFF_ERRCLR, 32'h2);
		rd(ebc_pkg::OFF_RAWSTS, 32'h0);
		wr(ebc_pkg::OFF_FIFOCFG, 32'h0);
		pulse(0);
		pulse(1);
		rd(ebc_pkg::OFF_ERRSTS, 32'h0);
		wr_fill <= 5'h0;
		wr(ebc_pkg::OFF_INTEN, 32'h1);
		rd(ebc_pkg::OFF_MSKSTS, 32'h1);
		cmp(irq, 32'h1);
		$display("test errors done");
		for (i = 0; i < 3; i++) begin
			wr(ebc_pkg::OFF_MAXWAIT, 32'(mw[i]));
			hold_len <= 8'(hl[i]);
			xact_busy <= 1'b1;
			count(30);
			xact_busy <= 1'b0;
			cmp(32'(ab != 0), 32'(i == 1));
			rd(ebc_pkg::OFF_ERRSTS, 32'(4 * (i == 1)));
			wr(ebc_pkg::OFF_ERRCLR, 32'h7);
		end
		$display("test timeout done");
		conclude();
	end

	// hang guard: the full run needs about a thousand cycles
	initial begin : watchdog
		#100000;
		error_cnt++;
		$display("Error at %0t: watchdog expired", $time);
		conclude();
	end
endmodule : test_external_bus_ctrl_core
